/* File: adcrs_regs.svh */
`ifndef ADCRS_REGS_SVH
`define ADCRS_REGS_SVH

// ****************************************************************
// Register offsets (10-bit byte addresses)
// ****************************************************************
`define ADCRS_CTL0_OFS      10'h3D6
`define ADCRS_CTL1_OFS      10'h3D7
`define ADCRS_CTL2_OFS      10'h3D4
`define ADCRS_RES_BASE_HI   6'h3C
`define ADCRS_RES_STRIDE    2

// ****************************************************************
// Reset values
// ****************************************************************
`define ADCRS_CTL0_RST      8'h00
`define ADCRS_CTL1_RST      8'h00
`define ADCRS_CTL2_RST      8'h00

// ****************************************************************
// Field positions, control register 0
// ****************************************************************
`define ADCRS_C0_CH_LSB     0
`define ADCRS_C0_CH_MSB     2
`define ADCRS_C0_MD_LSB     3
`define ADCRS_C0_MD_MSB     4
`define ADCRS_C0_TRG        5
`define ADCRS_C0_CONVERSION_START_FLAG       6
`define ADCRS_C0_CKS0       7

// ****************************************************************
// Field positions, control registers 1 and 2
// ****************************************************************
`define ADCRS_C1_SCAN_LSB   0
`define ADCRS_C1_SCAN_MSB   1
`define ADCRS_C1_MD2        2
`define ADCRS_C1_BITS       3
`define ADCRS_C2_GSEL_LSB   1
`define ADCRS_C2_GSEL_MSB   2

// ****************************************************************
// Encodings
// ****************************************************************
`define ADCRS_MODE_REPEAT   2'h3
`define ADCRS_RES_DEPTH     8
`define ADCRS_RES_WIDTH     10

`endif

/* File: adcrs_pkg.sv */
package adcrs_pkg;

  // ****************************************************************
  // Sweep sequencer states
  // ****************************************************************
  typedef enum logic [1:0] {
    ADCRS_IDLE,
    ADCRS_ARMED,
    ADCRS_CONV
  } adcrs_fsm_t;

  // ****************************************************************
  // State of the top module, apart from the result store
  // ****************************************************************
  typedef struct packed {
    logic [7:0]  ctl0;
    logic [7:0]  ctl1;
    logic [7:0]  ctl2;
    adcrs_fsm_t  fsm;
    logic [2:0]  chan;
    logic        trig_s1;
    logic        trig_s2;
    logic        trig_prev;
    logic        conv_start;
    logic        irq;
    logic        active;
    logic [15:0] rd_data;
  } adcrs_state_t;

  typedef logic [9:0]  adcrs_addr_t;
  typedef logic [15:0] adcrs_data_t;

endpackage

/* File: adcrs_result_mem.sv */
`timescale 1ns/10ps
// ****************************************************************
// Per-channel result store
// ****************************************************************
module adcrs_result_mem #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 10,
  parameter int AW    = 3
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst_n,
  input  wire logic             i_wr_en,
  input  wire logic [AW-1:0]    i_wr_idx,
  input  wire logic [WIDTH-1:0] i_wr_data,
  input  wire logic [AW-1:0]    i_rd_idx,
  output logic      [WIDTH-1:0] o_rd_data
);

  logic [DEPTH-1:0][WIDTH-1:0] mem_r;
  logic [DEPTH-1:0][WIDTH-1:0] mem_nxt;

  always_comb begin
    mem_nxt = mem_r;
    if (i_wr_en) begin
      mem_nxt[i_wr_idx] = i_wr_data;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      mem_r <= '0;
    end else begin
      mem_r <= mem_nxt;
    end
  end

  // Entries are flip-flops; the caller registers the read value.
  assign o_rd_data = mem_r[i_rd_idx];

endmodule // adcrs_result_mem

/* File: adcrs_top.sv */
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps
`include "adcrs_regs.svh"
module adcrs_top (
  input  wire logic               i_clk_sys,
  input  wire logic               i_rst_n,
  input  wire adcrs_pkg::adcrs_addr_t i_addr,
  input  wire adcrs_pkg::adcrs_data_t i_wr_data,
  input  wire logic               i_wr_en,
  input  wire logic               i_rd_en,
  output adcrs_pkg::adcrs_data_t  o_rd_data,
  input  wire logic               i_external_trigger_input,
  input  wire logic               i_conv_done,
  input  wire logic [9:0]         i_conv_data,
  output logic                    o_conv_start,
  output logic [2:0]              o_conv_chan,
  output logic [1:0]              o_conv_group,
  output logic                    o_conv_10bit,
  output logic                    o_sweep_active,
  output logic                    o_conv_irq
);
  import adcrs_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  adcrs_state_t st_r;
  adcrs_state_t st_nxt;

  // ****************************************************************
  // Decoded fields
  // ****************************************************************
  logic [1:0]  mode_sel;
  logic        trig_sel;
  logic        start_flag;
  logic [1:0]  sweep_sel;
  logic        mode_bit2;
  logic        res_10bit;
  logic [1:0]  group_sel;
  logic        mode_ok;
  logic [2:0]  last_chan;
  logic        trig_fall;
  logic        res_hit;
  logic [2:0]  res_idx;
  logic        mem_wr_en;
  logic [9:0]  mem_wr_data;
  logic [9:0]  mem_rd_data;
  logic        sweep_ok;
  logic        soft_go;
  logic        ext_go;
  logic [2:0]  chan_adv;

  assign mode_sel   = st_r.ctl0[`ADCRS_C0_MD_MSB:`ADCRS_C0_MD_LSB];
  assign trig_sel   = st_r.ctl0[`ADCRS_C0_TRG];
  assign start_flag = st_r.ctl0[`ADCRS_C0_CONVERSION_START_FLAG];
  assign sweep_sel  = st_r.ctl1[`ADCRS_C1_SCAN_MSB:`ADCRS_C1_SCAN_LSB];
  assign mode_bit2  = st_r.ctl1[`ADCRS_C1_MD2];
  assign res_10bit  = st_r.ctl1[`ADCRS_C1_BITS];
  assign group_sel  = st_r.ctl2[`ADCRS_C2_GSEL_MSB:`ADCRS_C2_GSEL_LSB];

  // Repeat sweep mode 0 needs mode field 11 with the extra mode bit clear.
  assign mode_ok = (mode_sel == `ADCRS_MODE_REPEAT) && !mode_bit2;

  // The last channel of the sweep is odd: 1, 3, 5 or 7.
  // The single-channel bits of control register 0 are deliberately unused here.
  assign last_chan = {sweep_sel, 1'b1};

  // The first synchroniser stage feeds only the second one.
  assign trig_fall = st_r.trig_prev && !st_r.trig_s2;

  // ****************************************************************
  // Start conditions
  // ****************************************************************
  // A flag left at 1 in another mode stays inert, and becomes live again
  // without a new write once the mode field returns to repeat sweep.
  assign sweep_ok = start_flag && mode_ok;
  assign soft_go  = sweep_ok && !trig_sel;
  assign ext_go   = sweep_ok && trig_sel && trig_fall;

  // ****************************************************************
  // Sweep advance
  // ****************************************************************
  // Wrapping at or beyond the last channel, not at seven, keeps a sweep whose
  // length was shortened mid-run from reaching inputs that were deselected.
  always_comb begin
    if (st_r.chan >= last_chan) begin
      chan_adv = 3'h0;
    end else begin
      chan_adv = st_r.chan + 3'h1;
    end
  end

  // ****************************************************************
  // Result register address decode
  // ****************************************************************
  assign res_hit = (i_addr[9:4] == `ADCRS_RES_BASE_HI) && !i_addr[0];
  assign res_idx = i_addr[3:1];

  // ****************************************************************
  // Result capture
  // ****************************************************************
  // A result is only taken while a conversion is outstanding, so a late
  // completion after a halt cannot overwrite a stored value.
  assign mem_wr_en = (st_r.fsm == ADCRS_CONV) && i_conv_done;

  always_comb begin
    if (res_10bit) begin
      mem_wr_data = i_conv_data;
    end else begin
      mem_wr_data = {2'h0, i_conv_data[7:0]};
    end
  end

  adcrs_result_mem #(
    .DEPTH (`ADCRS_RES_DEPTH),
    .WIDTH (`ADCRS_RES_WIDTH),
    .AW    (3)
  ) u_result_mem (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_wr_en   (mem_wr_en),
    .i_wr_idx  (st_r.chan),
    .i_wr_data (mem_wr_data),
    .i_rd_idx  (res_idx),
    .o_rd_data (mem_rd_data)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_nxt            = st_r;
    st_nxt.trig_s1    = i_external_trigger_input;
    st_nxt.trig_s2    = st_r.trig_s1;
    st_nxt.trig_prev  = st_r.trig_s2;
    st_nxt.conv_start = 1'b0;
    st_nxt.irq        = 1'b0;
    st_nxt.rd_data    = '0;

    // Register writes. Only the low byte carries control bits.
    if (i_wr_en) begin
      case (i_addr)
        `ADCRS_CTL0_OFS: begin
          st_nxt.ctl0 = i_wr_data[7:0];
        end
        `ADCRS_CTL1_OFS: begin
          st_nxt.ctl1 = i_wr_data[7:0];
        end
        `ADCRS_CTL2_OFS: begin
          st_nxt.ctl2 = i_wr_data[7:0];
        end
        default: begin
        end
      endcase
    end

    // Register reads; unmapped addresses answer zero.
    if (i_rd_en) begin
      case (i_addr)
        `ADCRS_CTL0_OFS: begin
          st_nxt.rd_data = {8'h00, st_r.ctl0};
        end
        `ADCRS_CTL1_OFS: begin
          st_nxt.rd_data = {8'h00, st_r.ctl1};
        end
        `ADCRS_CTL2_OFS: begin
          st_nxt.rd_data = {8'h00, st_r.ctl2};
        end
        default: begin
          if (res_hit) begin
            st_nxt.rd_data = {6'h00, mem_rd_data};
          end
        end
      endcase
    end

    // Sweep sequencer. The flag is only ever cleared by software, so the
    // sweep has no natural end and no completion event to report.
    case (st_r.fsm)
      ADCRS_IDLE: begin
        if (soft_go) begin
          st_nxt.fsm        = ADCRS_CONV;
          st_nxt.chan       = 3'h0;
          st_nxt.conv_start = 1'b1;
        end else if (sweep_ok) begin
          // A falling edge in this very cycle is not counted; the pin must
          // fall again once the sequencer is armed.
          st_nxt.fsm = ADCRS_ARMED;
        end
      end
      ADCRS_ARMED: begin
        if (!sweep_ok) begin
          st_nxt.fsm = ADCRS_IDLE;
        end else if (soft_go || ext_go) begin
          // Edges seen before the flag was set never reach this state. A switch
          // back to the software trigger starts at once, as a flag write would.
          st_nxt.fsm        = ADCRS_CONV;
          st_nxt.chan       = 3'h0;
          st_nxt.conv_start = 1'b1;
        end
      end
      ADCRS_CONV: begin
        if (!sweep_ok) begin
          st_nxt.fsm = ADCRS_IDLE;
        end else if (i_conv_done) begin
          st_nxt.conv_start = 1'b1;
          st_nxt.chan       = chan_adv;
        end
      end
      default: begin
        st_nxt.fsm = ADCRS_IDLE;
      end
    endcase
    st_nxt.active = (st_nxt.fsm == ADCRS_CONV);
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      st_r      <= '0;
      st_r.ctl0 <= `ADCRS_CTL0_RST;
      st_r.ctl1 <= `ADCRS_CTL1_RST;
      st_r.ctl2 <= `ADCRS_CTL2_RST;
      st_r.fsm  <= ADCRS_IDLE;
      // The trigger chain starts at the pin's idle high level.
      st_r.trig_s1   <= 1'b1;
      st_r.trig_s2   <= 1'b1;
      st_r.trig_prev <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign o_rd_data      = st_r.rd_data;
  assign o_conv_start   = st_r.conv_start;
  assign o_conv_chan    = st_r.chan;
  assign o_conv_group   = group_sel;
  assign o_conv_10bit   = st_r.ctl1[`ADCRS_C1_BITS];
  assign o_sweep_active = st_r.active;
  assign o_conv_irq     = st_r.irq;

endmodule // adcrs_top

/* File: adcrs_properties.sv */
`timescale 1ns/10ps
module adcrs_properties (
  input wire logic                   i_clk_sys,
  input wire logic                   i_rst_n,
  input wire adcrs_pkg::adcrs_addr_t i_addr,
  input wire adcrs_pkg::adcrs_data_t i_wr_data,
  input wire logic                   i_wr_en,
  input wire logic                   i_rd_en,
  input wire adcrs_pkg::adcrs_data_t o_rd_data,
  input wire logic                   i_conv_done,
  input wire logic                   o_conv_start,
  input wire logic [2:0]             o_conv_chan,
  input wire logic [1:0]             o_conv_group,
  input wire logic                   o_conv_10bit,
  input wire logic                   o_sweep_active,
  input wire logic                   o_conv_irq
);
  import adcrs_pkg::*;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  logic [2:0] last_r;
  logic       md2_r;
  wire        w0 = i_wr_en && i_addr == 10'h3D6;
  // Sweep length and the extra mode bit are shadowed from bus writes, as the register is not a port.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      last_r <= 3'h1;
      md2_r  <= 1'b0;
    end else if (i_wr_en && i_addr == 10'h3D7) begin
      last_r <= {i_wr_data[1:0], 1'b1};
      md2_r  <= i_wr_data[2];
    end
  end
  sequence s_go;
    w0 && i_wr_data[6:3] == 4'hB && !o_sweep_active && !md2_r;
  endsequence
  sequence s_first;
    o_conv_start && o_conv_chan == 3'h0;
  endsequence
  sequence s_done;
    i_conv_done && o_sweep_active && !i_wr_en && !$past(i_wr_en);
  endsequence
  a_irq_quiet: assert property (!o_conv_irq)
    else $error("interrupt raised");
  a_soft_start: assert property (s_go |-> ##2 s_first)
    else $error("no start after flag write");
  a_start_single: assert property (o_conv_start |=> !o_conv_start)
    else $error("start pulse too long");
  a_chan_next: assert property (s_done |=> o_conv_start && o_conv_chan ==
    (($past(o_conv_chan) >= last_r) ? 3'h0 : $past(o_conv_chan) + 3'h1))
    else $error("wrong next channel");
  a_sweep_first: assert property ($rose(o_sweep_active) |-> s_first)
    else $error("sweep not from channel 0");
  a_stop_halts: assert property (w0 && !i_wr_data[6] |->
    ##2 (!o_sweep_active && !o_conv_start) [*4])
    else $error("sweep not halted");
  a_group_out: assert property (i_wr_en && i_addr == 10'h3D4 |->
    ##2 o_conv_group == $past(i_wr_data[2:1], 2))
    else $error("group select not applied");
  a_res_out: assert property (i_wr_en && i_addr == 10'h3D7 |->
    ##2 o_conv_10bit == $past(i_wr_data[3], 2))
    else $error("resolution not applied");
  a_rd_idle: assert property (!$past(i_rd_en) |-> o_rd_data == 16'h0000)
    else $error("read data outside read cycle");
endmodule // adcrs_properties

bind adcrs_top adcrs_properties adcrs_properties_inst (
  .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wr_data(i_wr_data),
  .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data), .i_conv_done(i_conv_done),
  .o_conv_start(o_conv_start), .o_conv_chan(o_conv_chan), .o_conv_group(o_conv_group),
  .o_conv_10bit(o_conv_10bit), .o_sweep_active(o_sweep_active), .o_conv_irq(o_conv_irq));

/* File: adcrs_analog_model.sv */
`timescale 1ns/10ps
module adcrs_analog_model (
  input  wire logic       i_clk_sys,
  input  wire logic       i_conv_start,
  input  wire logic [2:0] i_conv_chan,
  input  wire logic [1:0] i_conv_group,
  input  wire logic       i_slow,
  output logic            o_conv_done = 1'b0,
  output logic [9:0]      o_conv_data = 10'h000,
  output logic            o_trigger = 1'b1
);
  int wait_q = 0;
  // Between results the data bus toggles, so a stale value never passes as valid.
  always @(posedge i_clk_sys) begin
    o_conv_done <= 1'b0;
    o_conv_data <= ~o_conv_data;
    if (i_conv_start) begin
      wait_q <= i_slow ? 6 : 1;
    end else if (wait_q == 1) begin
      o_conv_done <= 1'b1;
      o_conv_data <= {3'h6, i_conv_group, 2'h1, i_conv_chan};
      wait_q <= 0;
    end else if (wait_q > 1) begin
      wait_q <= wait_q - 1;
    end
  end
  task automatic fire();
    o_trigger <= 1'b0;
    repeat (5) @(posedge i_clk_sys);
    o_trigger <= 1'b1;
    @(posedge i_clk_sys);
  endtask
endmodule // adcrs_analog_model

/* File: adcrs_test.sv */
`timescale 1ns/10ps
module adcrs_test;
  import adcrs_pkg::*;
  logic        i_clk_sys = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        i_wr_en = 1'b0;
  logic        i_rd_en = 1'b0;
  logic        slow = 1'b0;
  adcrs_addr_t i_addr = 10'h000;
  adcrs_data_t i_wr_data = 16'h0000;
  adcrs_data_t o_rd_data;
  logic        done, start, trig, tenbit, active, irq;
  logic [9:0]  cdata;
  logic [2:0]  chan;
  logic [1:0]  group;
  int          fails = 0;
  int          n_compared = 0;
  int          cycles = 0;
  always #2 i_clk_sys = ~i_clk_sys;
  adcrs_top adcrs_top_inst (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data),
    .i_external_trigger_input(trig), .i_conv_done(done), .i_conv_data(cdata),
    .o_conv_start(start), .o_conv_chan(chan), .o_conv_group(group), .o_conv_10bit(tenbit),
    .o_sweep_active(active), .o_conv_irq(irq));
  adcrs_analog_model adcrs_analog_model_inst (.i_clk_sys(i_clk_sys), .i_conv_start(start),
    .i_conv_chan(chan), .i_conv_group(group), .i_slow(slow), .o_conv_done(done),
    .o_conv_data(cdata), .o_trigger(trig));
  // ****************************************************************
  // Bus tasks and checks
  // ****************************************************************
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input adcrs_data_t e, input adcrs_data_t g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input adcrs_addr_t a, input logic [7:0] d);
    i_wr_en <= 1'b1;
    i_addr <= a;
    i_wr_data <= {8'h00, d};
    @(posedge i_clk_sys);
    i_wr_en <= 1'b0;
    // The next call raises the strobe a step later, never in this time step.
    #1;
  endtask
  // Data are taken just after the edge that ends the read, the only cycle they stand.
  task automatic rd(input adcrs_addr_t a, input adcrs_data_t e);
    i_rd_en <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd_en <= 1'b0;
    #1 chk($sformatf("reg %h", a), e, o_rd_data);
  endtask
  function automatic adcrs_data_t expv(input logic [1:0] g, input logic [2:0] n, input logic b);
    logic [9:0] v;
    v = {3'h6, g, 2'h1, n};
    return b ? {6'h00, v} : {8'h00, v[7:0]};
  endfunction
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      results();
    end
  end
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (12) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    @(posedge i_clk_sys);
    rd(10'h3D6, 16'h0000);
    rd(10'h3D7, 16'h0000);
    rd(10'h3D4, 16'h0000);
    wr(10'h100, 8'hFF);
    rd(10'h100, 16'h0000);
    for (int s = 0; s < 4; s++) begin
      wr(10'h3D4, {5'h00, s[1:0], 1'b0});
      chk("group", {14'h0000, s[1:0]}, {14'h0000, group});
      wr(10'h3D7, {4'h0, ~s[1], 1'b0, s[1:0]});
      chk("tenbit", {15'h0000, ~s[1]}, {15'h0000, tenbit});
      slow <= s[0];
      wr(10'h3D6, {5'h0B, s[2:0] + 3'h5});
      repeat (220) @(posedge i_clk_sys);
      wr(10'h3D6, 8'h18);
      repeat (10) @(posedge i_clk_sys);
      for (int n = 0; n < 2 * s + 2; n++) begin
        rd(10'h3C0 + 10'(2 * n), expv(s[1:0], n[2:0], ~s[1]));
      end
      if (s == 0) rd(10'h3C4, 16'h0000);
    end
    wr(10'h3C0, 8'hAA);
    rd(10'h3C0, expv(2'h3, 3'h0, 1'b0));
    wr(10'h3D6, 8'h38);
    adcrs_analog_model_inst.fire();
    wr(10'h3D6, 8'h78);
    repeat (20) @(posedge i_clk_sys);
    #1 chk("armed idle", 16'h0000, {15'h0000, active});
    adcrs_analog_model_inst.fire();
    #1 chk("ext start", 16'h0001, {15'h0000, active});
    wr(10'h3D6, 8'h18);
    repeat (10) @(posedge i_clk_sys);
    #1 chk("halted", 16'h0000, {15'h0000, active});
    wr(10'h3D6, 8'h40);
    repeat (10) @(posedge i_clk_sys);
    #1 chk("mode 00", 16'h0000, {15'h0000, active});
    wr(10'h3D7, 8'h04);
    wr(10'h3D6, 8'h58);
    repeat (10) @(posedge i_clk_sys);
    #1 chk("mode bit2", 16'h0000, {15'h0000, active});
    chk("irq", 16'h0000, {15'h0000, irq});
    results();
  end
endmodule // adcrs_test
